// [hw/arcc_regs.vh]
`ifndef ARCC_REGS_VH
`define ARCC_REGS_VH
// Register byte addresses
`define ARCC_A_UPLIM 8'h10
`define ARCC_A_GAIN 8'h12
`define ARCC_A_OFFS 8'h14
`define ARCC_A_TRIG 8'h18
`define ARCC_A_DBG 8'h1C
`define ARCC_A_SYNC 8'h20
`define ARCC_A_RES 8'h24
// Own control registers
`define ARCC_A_CFGC 8'h30
`define ARCC_A_AVG 8'h31
`define ARCC_A_LOLIM 8'h32
`define ARCC_A_CTRLA 8'h33
`define ARCC_A_SAMP 8'h34
`define ARCC_A_INSEL 8'h35
`define ARCC_A_STAT 8'h36
// Trigger bits
`define ARCC_TRIG_START 1
`define ARCC_TRIG_FLUSH 0
// Control C fields
`define ARCC_C_LEFT 1
`define ARCC_C_CORR 3
`define ARCC_C_WM_HI 10
`define ARCC_C_WM_LO 8
// Control A bits
`define ARCC_A_SRST_B 0
`define ARCC_A_EN_B 1
// Averaging sample count field
`define ARCC_AVG_N_HI 3
// Sync flag positions
`define ARCC_S_SRST 0
`define ARCC_S_EN 1
`define ARCC_S_INSEL 2
`define ARCC_S_CFGC 3
`define ARCC_S_AVG 4
`define ARCC_S_SAMP 5
`define ARCC_S_LOLIM 6
`define ARCC_S_UPLIM 7
`define ARCC_S_GAIN 8
`define ARCC_S_OFFS 9
`define ARCC_S_TRIG 10
// Timing
`define ARCC_SYNC_CYC 4'h3
`define ARCC_CORR_CYC 5'h0D
`define ARCC_SAMPLE_MAX 11'h400
// Window modes
`define ARCC_WM_OFF 3'h0
`define ARCC_WM_ABOVE 3'h1
`define ARCC_WM_BELOW 3'h2
`define ARCC_WM_IN 3'h3
`define ARCC_WM_OUT 3'h4
`endif

// [hw/arcc_sync_flag.v]
`timescale 1ns/1ps
`default_nettype none
`include "arcc_regs.vh"
module arcc_sync_flag (
    input wire clk_in,
    input wire rst_n_in,
    input wire start_in,
    output reg busy_out,
    output reg done_out
);
    reg [3:0] cnt_q;
    // Busy window models the bus-to-converter crossing time
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 4'h0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                cnt_q <= `ARCC_SYNC_CYC;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (cnt_q == 4'h1) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule // arcc_sync_flag
`default_nettype wire

// [hw/arcc_corr.v]
`timescale 1ns/1ps
`default_nettype none
`include "arcc_regs.vh"
module arcc_corr (
    input wire clk_in,
    input wire rst_n_in,
    input wire go_in,
    input wire [15:0] raw_in,
    input wire [11:0] gain_in,
    input wire [11:0] offs_in,
    output reg [15:0] val_out
);
    wire signed [17:0] sub_w;
    wire [29:0] prod_w;
    // Offset subtracted first, then scaled by 1.11 gain
    assign sub_w = $signed({2'b00, raw_in}) - $signed({{6{offs_in[11]}}, offs_in});
    assign prod_w = (sub_w[17] ? 30'h0 : {12'h000, sub_w}) * {18'h0, gain_in};
    // Saturate to 12 bits
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            val_out <= 16'h0000;
        end else if (go_in) begin
            if (prod_w[29:23] != 7'h00)
                val_out <= 16'h0FFF;
            else
                val_out <= {4'h0, prod_w[22:11]};
        end
    end
endmodule // arcc_corr
`default_nettype wire

// [hw/arcc_top.v]
// Contract
// - Upper threshold bounds the window compare
// - Gain correction applied when enabled
// - Gain is unsigned 1.11 fixed point
// - Signed offset correction applied when enabled
// - Start begins conversion, cleared on start
// - Repeat start or zero writes ignored
// - Flush aborts conversions, restarts converter
// - Pending request restarts after flush
// - Debug halt stops converter unless overridden
// - Halt override survives soft reset
// - Busy flag spans each register crossing
// - Status bits 10..8 trigger, offset, gain
// - Status bits 7..0 other registers
// - Result is 16 bits, 12 single
// - Left align puts result high
// - Right align into bits 11..0
// - Oversampled sum fills bits 15..0
// - Correction adds 13 converter cycles
// - Window mode 0 off, 1..4, rest reserved
`timescale 1ns/1ps
`default_nettype none
`include "arcc_regs.vh"
module arcc_top (
    input wire clk_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    input wire dbg_halt_in,
    input wire adc_done_in,
    input wire [11:0] adc_data_in,
    output reg adc_start_out,
    output reg adc_flush_out,
    output reg win_hit_out,
    output reg res_ready_out
);
    localparam ST_IDLE = 5'b00001;
    localparam ST_CONV = 5'b00010;
    localparam ST_ACC = 5'b00100;
    localparam ST_CORR = 5'b01000;
    localparam ST_DONE = 5'b10000;

    reg [15:0] uplim_q, lolim_q;
    reg [11:0] gain_q, offs_q;
    reg [15:0] cfgc_q;
    reg [7:0] avg_q, samp_q, insel_q;
    reg enable_q, hovr_q, start_q, pend_q;
    reg trig_start_q, trig_flush_q;
    reg [15:0] result_q;
    reg [4:0] state_q;
    reg [4:0] ccnt_q;
    reg [10:0] scnt_q;
    reg [21:0] acc_q;
    reg [15:0] raw_q;
    reg go_corr_q;
    wire [15:0] corr_w;
    wire [10:0] busy_w;
    wire [10:0] sdone_w;
    wire [10:0] wstart_w;
    wire run_w;
    wire [2:0] wmode_w;

    // Flag-start decode per synchronized register
    function is_wr;
        input [7:0] a;
        input [7:0] b;
        input w;
        is_wr = w && (a == b);
    endfunction

    assign wstart_w[`ARCC_S_SRST] = is_wr(addr_in, `ARCC_A_CTRLA, wr_in)
        && wdata_in[`ARCC_A_SRST_B];
    assign wstart_w[`ARCC_S_EN] = is_wr(addr_in, `ARCC_A_CTRLA, wr_in);
    assign wstart_w[`ARCC_S_INSEL] = is_wr(addr_in, `ARCC_A_INSEL, wr_in);
    assign wstart_w[`ARCC_S_CFGC] = is_wr(addr_in, `ARCC_A_CFGC, wr_in);
    assign wstart_w[`ARCC_S_AVG] = is_wr(addr_in, `ARCC_A_AVG, wr_in);
    assign wstart_w[`ARCC_S_SAMP] = is_wr(addr_in, `ARCC_A_SAMP, wr_in);
    assign wstart_w[`ARCC_S_LOLIM] = is_wr(addr_in, `ARCC_A_LOLIM, wr_in);
    assign wstart_w[`ARCC_S_UPLIM] = is_wr(addr_in, `ARCC_A_UPLIM, wr_in);
    assign wstart_w[`ARCC_S_GAIN] = is_wr(addr_in, `ARCC_A_GAIN, wr_in);
    assign wstart_w[`ARCC_S_OFFS] = is_wr(addr_in, `ARCC_A_OFFS, wr_in);
    assign wstart_w[`ARCC_S_TRIG] = is_wr(addr_in, `ARCC_A_TRIG, wr_in)
        && (wdata_in[`ARCC_TRIG_START] || wdata_in[`ARCC_TRIG_FLUSH]);

    // One busy tracker per register crossing
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
            arcc_sync_flag u_flag (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .start_in(wstart_w[gi]),
                .busy_out(busy_w[gi]),
                .done_out(sdone_w[gi])
            );
        end
    endgenerate

    arcc_corr u_corr (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .go_in(go_corr_q),
        .raw_in(raw_q),
        .gain_in(gain_q),
        .offs_in(offs_q),
        .val_out(corr_w)
    );

    // Converter runs while enabled, unless halted by the debugger without override
    assign run_w = enable_q && (hovr_q || !dbg_halt_in);
    assign wmode_w = cfgc_q[`ARCC_C_WM_HI:`ARCC_C_WM_LO];

    // Control registers; soft reset clears all but the halt override
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            uplim_q <= 16'h0000;
            lolim_q <= 16'h0000;
            gain_q <= 12'h000;
            offs_q <= 12'h000;
            cfgc_q <= 16'h0000;
            avg_q <= 8'h00;
            samp_q <= 8'h00;
            insel_q <= 8'h00;
            enable_q <= 1'b0;
            hovr_q <= 1'b0;
        end else if (sdone_w[`ARCC_S_SRST]) begin
            uplim_q <= 16'h0000;
            lolim_q <= 16'h0000;
            gain_q <= 12'h000;
            offs_q <= 12'h000;
            cfgc_q <= 16'h0000;
            avg_q <= 8'h00;
            samp_q <= 8'h00;
            insel_q <= 8'h00;
            enable_q <= 1'b0; // (hovr_q kept)
        end else if (wr_in) begin
            case (addr_in)
                `ARCC_A_UPLIM: uplim_q <= wdata_in;
                `ARCC_A_LOLIM: lolim_q <= wdata_in;
                `ARCC_A_GAIN: gain_q <= wdata_in[11:0];
                `ARCC_A_OFFS: offs_q <= wdata_in[11:0];
                `ARCC_A_CFGC: cfgc_q <= wdata_in;
                `ARCC_A_AVG: avg_q <= wdata_in[7:0];
                `ARCC_A_SAMP: samp_q <= wdata_in[7:0];
                `ARCC_A_INSEL: insel_q <= wdata_in[7:0];
                `ARCC_A_CTRLA: enable_q <= wdata_in[`ARCC_A_EN_B];
                `ARCC_A_DBG: hovr_q <= wdata_in[0];
                default: ;
            endcase
        end
    end

    // Conversion sequencer
    always @(posedge clk_in) begin
        if (!rst_n_in || sdone_w[`ARCC_S_SRST]) begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
            pend_q <= 1'b0;
            ccnt_q <= 5'h00;
            scnt_q <= 11'h000;
            acc_q <= 22'h000000;
            raw_q <= 16'h0000;
            go_corr_q <= 1'b0;
            result_q <= 16'h0000;
            adc_start_out <= 1'b0;
            adc_flush_out <= 1'b0;
            win_hit_out <= 1'b0;
            res_ready_out <= 1'b0;
        end else begin
            adc_start_out <= 1'b0;
            adc_flush_out <= 1'b0;
            res_ready_out <= 1'b0;
            go_corr_q <= 1'b0;
            // Start accepted only once crossing done; repeat start ignored
            if (sdone_w[`ARCC_S_TRIG] && !start_q && trig_start_q)
                start_q <= 1'b1;
            if (sdone_w[`ARCC_S_TRIG] && trig_flush_q) begin
                // Abort and drop in-flight data, remember request
                adc_flush_out <= 1'b1;
                pend_q <= (state_q != ST_IDLE) || start_q;
                state_q <= ST_IDLE;
                acc_q <= 22'h000000;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (run_w && (start_q || pend_q)) begin
                            adc_start_out <= 1'b1;
                            start_q <= 1'b0;
                            pend_q <= 1'b0;
                            scnt_q <= 11'h001 << avg_q[`ARCC_AVG_N_HI:0];
                            acc_q <= 22'h000000;
                            state_q <= ST_CONV;
                        end
                    end
                    ST_CONV: begin
                        if (run_w && adc_done_in) begin
                            acc_q <= acc_q + {10'h000, adc_data_in};
                            state_q <= ST_ACC;
                        end
                    end
                    ST_ACC: begin
                        if (scnt_q > 11'h001) begin
                            scnt_q <= scnt_q - 11'h001;
                            adc_start_out <= 1'b1;
                            state_q <= ST_CONV;
                        end else begin
                            // Sum scaled down by adjust field
                            raw_q <= acc_sh(acc_q, avg_q[6:4]);
                            ccnt_q <= `ARCC_CORR_CYC;
                            go_corr_q <= cfgc_q[`ARCC_C_CORR];
                            state_q <= cfgc_q[`ARCC_C_CORR] ? ST_CORR
                                : ST_DONE;
                        end
                    end
                    ST_CORR: begin
                        // Correction stretches the conversion
                        if (run_w) begin
                            ccnt_q <= ccnt_q - 5'h01;
                            if (ccnt_q == 5'h01)
                                state_q <= ST_DONE;
                        end
                    end
                    ST_DONE: begin
                        // Publish only the finished value
                        result_q <= fmt(cfgc_q[`ARCC_C_CORR] ? corr_w
                            : raw_q);
                        win_hit_out <= win(cfgc_q[`ARCC_C_CORR] ? corr_w
                            : raw_q);
                        res_ready_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Captured trigger bits for the crossing
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            trig_start_q <= 1'b0;
            trig_flush_q <= 1'b0;
        end else if (wstart_w[`ARCC_S_TRIG]) begin
            trig_start_q <= wdata_in[`ARCC_TRIG_START];
            trig_flush_q <= wdata_in[`ARCC_TRIG_FLUSH];
        end
    end

    // Shift the oversampled sum right by the adjust field
    function [15:0] acc_sh;
        input [21:0] a;
        input [2:0] s;
        reg [21:0] t;
        begin
            t = a >> s;
            acc_sh = (t[21:16] != 6'h00) ? 16'hFFFF : t[15:0];
        end
    endfunction

    // Alignment; one sample is a 12-bit value
    function [15:0] fmt;
        input [15:0] v;
        begin
            if (avg_q[`ARCC_AVG_N_HI:0] != 4'h0)
                fmt = v;
            else if (cfgc_q[`ARCC_C_LEFT])
                fmt = {v[11:0], 4'h0};
            else
                fmt = {4'h0, v[11:0]};
        end
    endfunction

    // Window compare
    function win;
        input [15:0] v;
        begin
            case (wmode_w)
                `ARCC_WM_ABOVE: win = v > lolim_q;
                `ARCC_WM_BELOW: win = v < uplim_q;
                `ARCC_WM_IN: win = (v > lolim_q) && (v < uplim_q);
                `ARCC_WM_OUT: win = (v < lolim_q) || (v > uplim_q);
                default: win = 1'b0;
            endcase
        end
    endfunction

    // Read port, data valid the cycle after the strobe
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                `ARCC_A_UPLIM: rdata_out <= uplim_q;
                `ARCC_A_LOLIM: rdata_out <= lolim_q;
                `ARCC_A_GAIN: rdata_out <= {4'h0, gain_q};
                `ARCC_A_OFFS: rdata_out <= {4'h0, offs_q};
                `ARCC_A_CFGC: rdata_out <= cfgc_q;
                `ARCC_A_AVG: rdata_out <= {8'h00, avg_q};
                `ARCC_A_SAMP: rdata_out <= {8'h00, samp_q};
                `ARCC_A_INSEL: rdata_out <= {8'h00, insel_q};
                `ARCC_A_CTRLA: rdata_out <= {14'h0000, enable_q, 1'b0};
                `ARCC_A_DBG: rdata_out <= {15'h0000, hovr_q};
                `ARCC_A_SYNC: rdata_out <= {5'h00, busy_w};
                `ARCC_A_RES: rdata_out <= result_q;
                `ARCC_A_STAT: rdata_out <= {11'h000, state_q};
                default: rdata_out <= 16'h0000; // Trigger is write-only
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule // arcc_top
`default_nettype wire

// [dv/arcc_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "arcc_regs.vh"
module arcc_top_sva (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic dbg_halt_in,
    input wire logic adc_done_in,
    input wire logic [11:0] adc_data_in,
    input wire logic adc_start_out,
    input wire logic adc_flush_out,
    input wire logic win_hit_out,
    input wire logic res_ready_out
);
    logic [7:0] since_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Age of the last raw sample, saturating so it never wraps
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            since_q <= 8'hFF;
        end else if (adc_done_in) begin
            since_q <= 8'h00;
        end else if (since_q != 8'hFF) begin
            since_q <= since_q + 8'h01;
        end
    end
    // A write followed two cycles later by a status read
    sequence gain_then_read;
        wr_in && addr_in == `ARCC_A_GAIN
        ##2 rd_in && addr_in == `ARCC_A_SYNC;
    endsequence
    sequence trig_then_read;
        wr_in && addr_in == `ARCC_A_TRIG && wdata_in[1:0] != 2'b00
        ##2 rd_in && addr_in == `ARCC_A_SYNC;
    endsequence
    // Quiet trigger path first, so no older crossing is still busy
    sequence zero_then_read;
        (!(wr_in && addr_in == `ARCC_A_TRIG))[*4]
        ##1 wr_in && addr_in == `ARCC_A_TRIG && wdata_in[1:0] == 2'b00
        ##2 rd_in && addr_in == `ARCC_A_SYNC;
    endsequence
    start_pulse_a: assert property (adc_start_out |=> !adc_start_out)
        else $error("start output longer than one cycle");
    flush_pulse_a: assert property (adc_flush_out |=> !adc_flush_out)
        else $error("flush output longer than one cycle");
    flush_req_a: assert property (
        wr_in && addr_in == `ARCC_A_TRIG && wdata_in[0] |-> ##[1:10] adc_flush_out)
        else $error("flush write gave no flush");
    gain_sync_a: assert property (gain_then_read |=> rdata_out[8])
        else $error("gain crossing not flagged");
    trig_sync_a: assert property (trig_then_read |=> rdata_out[10])
        else $error("trigger crossing not flagged");
    zero_trig_a: assert property (zero_then_read |=> !rdata_out[10])
        else $error("zero trigger write started a crossing");
    ready_pulse_a: assert property (res_ready_out |=> !res_ready_out)
        else $error("result ready longer than one cycle");
    ready_cause_a: assert property (res_ready_out |-> since_q < 8'h28)
        else $error("result update with no recent sample");
    hit_with_res_a: assert property (
        $changed(win_hit_out) |-> res_ready_out)
        else $error("window flag moved without a result");
endmodule // arcc_top_sva
bind arcc_top arcc_top_sva u_arcc_top_sva (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .dbg_halt_in(dbg_halt_in),
    .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
    .adc_start_out(adc_start_out), .adc_flush_out(adc_flush_out),
    .win_hit_out(win_hit_out), .res_ready_out(res_ready_out)
);
`default_nettype wire

// [dv/arcc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "arcc_regs.vh"
module arcc_top_bench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic dbg_halt_in = 1'b0;
    logic adc_done_in = 1'b0;
    logic [11:0] adc_data_in = 12'h000;
    wire [15:0] rdata_out;
    wire adc_start_out;
    wire adc_flush_out;
    wire win_hit_out;
    wire res_ready_out;
    int fails = 0;
    int checked = 0;
    int cnt [3] = '{0, 0, 0};
    logic [15:0] got;
    int lp;
    int lc;
    int d;
    int s;
    // 100 MHz clock
    always #5 clk_in = ~clk_in;
    arcc_top u_arcc_top (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .dbg_halt_in(dbg_halt_in),
        .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
        .adc_start_out(adc_start_out), .adc_flush_out(adc_flush_out),
        .win_hit_out(win_hit_out), .res_ready_out(res_ready_out)
    );
    // Pulse counters: start, flush, result ready
    always @(posedge clk_in) begin
        if (adc_start_out === 1'b1) cnt[0] <= cnt[0] + 1;
        if (adc_flush_out === 1'b1) cnt[1] <= cnt[1] + 1;
        if (res_ready_out === 1'b1) cnt[2] <= cnt[2] + 1;
    end
    task automatic finish_test();
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] a);
        checked++;
        if (a !== e) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", n, e, a);
        end
    endtask
    task automatic chk_n(input string n, input int e, input int a);
        checked++;
        if (a != e) begin
            fails++;
            $display("wrong value %s: expected %0d, seen %0d", n, e, a);
        end
    endtask
    // One strobe edge, then a quiet cycle so no signal is set twice at once
    task automatic op(input logic w, input logic [7:0] a,
                      input logic [15:0] v, output logic [15:0] q);
        wr_in <= w;
        rd_in <= ~w;
        addr_in <= a;
        wdata_in <= v;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        @(negedge clk_in);
        q = rdata_out;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic [15:0] q;
        op(1'b1, a, v, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        op(1'b0, a, 16'h0000, v);
    endtask
    // Bounded wait until pulse counter k passes base
    task automatic wait_ev(input int k, input int base, output int lat);
        lat = 0;
        while (cnt[k] <= base) begin
            @(posedge clk_in);
            lat++;
            if (lat > 100) begin
                fails++;
                $display("wrong value pulse %0d: expected one, seen none", k);
                finish_test();
            end
        end
    endtask
    // One raw sample; data shows its inverse when not qualified
    task automatic sample(input logic [11:0] raw, output int lat);
        int r;
        r = cnt[2];
        adc_done_in <= 1'b1;
        adc_data_in <= raw;
        @(posedge clk_in);
        adc_done_in <= 1'b0;
        adc_data_in <= ~raw;
        wait_ev(2, r, lat);
    endtask
    // Second start lands while the first is still crossing and restarts its busy window; one start expected
    task automatic conv(input logic [15:0] c, input logic [11:0] raw,
                        input logic [15:0] e, output int lat);
        int s0;
        int w;
        s0 = cnt[0];
        wr(`ARCC_A_CFGC, c);
        wr(`ARCC_A_TRIG, 16'h0002);
        wr(`ARCC_A_TRIG, 16'h0002);
        wait_ev(0, s0, w);
        sample(raw, lat);
        rd(`ARCC_A_RES, got);
        chk("result", e, got);
        chk_n("starts", s0 + 1, cnt[0]);
    endtask
    initial begin
        logic [7:0] ra [8] = '{`ARCC_A_UPLIM, `ARCC_A_GAIN, `ARCC_A_OFFS,
            `ARCC_A_TRIG, `ARCC_A_DBG, `ARCC_A_SYNC, `ARCC_A_RES, 8'h40};
        logic [7:0] sa [10] = '{`ARCC_A_CTRLA, `ARCC_A_GAIN, `ARCC_A_OFFS,
            `ARCC_A_UPLIM, `ARCC_A_CFGC, `ARCC_A_AVG, `ARCC_A_LOLIM,
            `ARCC_A_SAMP, `ARCC_A_INSEL, `ARCC_A_TRIG};
        logic [15:0] sb [10] = '{16'h0002, 16'h0100, 16'h0200, 16'h0080,
            16'h0008, 16'h0010, 16'h0040, 16'h0020, 16'h0004, 16'h0400};
        logic [2:0] wm [9] = '{0, 1, 1, 2, 2, 3, 3, 4, 0};
        logic [15:0] wl [9] = '{16'h0200, 16'h0200, 16'h0200, 16'h0200,
            16'h0200, 16'h0200, 16'h0200, 16'h0A00, 16'h0A00};
        logic [11:0] wv [9] = '{12'h500, 12'h500, 12'h100, 12'h900,
            12'h500, 12'h500, 12'h900, 12'h900, 12'h900};
        logic wh [9] = '{0, 1, 0, 0, 1, 1, 0, 1, 0};
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        // Reset values, write-only and unmapped reads give zero
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], got);
            chk("reset value", 16'h0000, got);
        end
        wr(`ARCC_A_UPLIM, 16'hA5C3);
        rd(`ARCC_A_UPLIM, got);
        chk("upper limit", 16'hA5C3, got);
        wr(`ARCC_A_GAIN, 16'h0FFF);
        rd(`ARCC_A_GAIN, got);
        chk("gain", 16'h0FFF, got);
        repeat (8) @(posedge clk_in);
        // Each write flags its own crossing, then clears
        for (int i = 0; i < 10; i++) begin
            wr(sa[i], (i == 0) ? 16'h0002 : {15'h0, i == 9});
            rd(`ARCC_A_SYNC, got);
            chk("busy set", sb[i], got);
            repeat (8) @(posedge clk_in);
            rd(`ARCC_A_SYNC, got);
            chk("busy clear", 16'h0000, got);
        end
        wr(`ARCC_A_TRIG, 16'h0000);
        rd(`ARCC_A_SYNC, got);
        chk("zero trigger", 16'h0000, got);
        s = cnt[1];
        wr(`ARCC_A_TRIG, 16'h0001);
        wait_ev(1, s, d);
        conv(16'h0000, 12'h5A3, 16'h05A3, lp);
        conv(16'h0002, 12'hABC, 16'hABC0, d);
        // Expected: (raw - offset) * gain / 2048, clamped to 12 bits
        wr(`ARCC_A_GAIN, 16'h0400);
        wr(`ARCC_A_OFFS, 16'h0000);
        conv(16'h0008, 12'h800, 16'h0400, lc);
        chk_n("corr latency", lp + 13, lc);
        wr(`ARCC_A_GAIN, 16'h0800);
        wr(`ARCC_A_OFFS, 16'h0010);
        conv(16'h0008, 12'h100, 16'h00F0, d);
        conv(16'h0008, 12'h005, 16'h0000, d);
        wr(`ARCC_A_GAIN, 16'h0C00);
        wr(`ARCC_A_OFFS, 16'h0FF0);
        conv(16'h0008, 12'h100, 16'h0198, d);
        wr(`ARCC_A_UPLIM, 16'h0800);
        for (int i = 0; i < 9; i++) begin
            wr(`ARCC_A_LOLIM, wl[i]);
            conv({5'h00, wm[i], 8'h00}, wv[i], {4'h0, wv[i]}, d);
            chk("hit", {15'h0, wh[i]}, {15'h0, win_hit_out});
        end
        // Override is changed only while idle
        wr(`ARCC_A_DBG, 16'h0000);
        dbg_halt_in <= 1'b1;
        s = cnt[0];
        wr(`ARCC_A_TRIG, 16'h0002);
        repeat (20) @(posedge clk_in);
        chk_n("halted starts", s, cnt[0]);
        dbg_halt_in <= 1'b0;
        wait_ev(0, s, d);
        sample(12'h321, d);
        wr(`ARCC_A_DBG, 16'h0001);
        dbg_halt_in <= 1'b1;
        s = cnt[0];
        wr(`ARCC_A_TRIG, 16'h0002);
        wait_ev(0, s, d);
        sample(12'h123, d);
        dbg_halt_in <= 1'b0;
        // Soft reset clears the rest but keeps the override
        wr(`ARCC_A_GAIN, 16'h0123);
        wr(`ARCC_A_CTRLA, 16'h0001);
        repeat (10) @(posedge clk_in);
        rd(`ARCC_A_DBG, got);
        chk("override kept", 16'h0001, got);
        rd(`ARCC_A_GAIN, got);
        chk("gain cleared", 16'h0000, got);
        finish_test();
    end
endmodule // arcc_top_bench
`default_nettype wire
